// [src/jps_pkg.sv]
/*
 * jps_pkg: constants and types for the test-port to serial-programming
 * switch. Assumes a 4-bit instruction register and an 8-bit vendor
 * command register, both clocked from the sampled test clock.
 */
package jps_pkg;

    // instruction register
    localparam int IR_WIDTH = 4;
    localparam logic [3:0] IR_RESET = 4'h1;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_VENDOR_CMD = 4'h8;

    // vendor command register
    localparam int CMD_WIDTH = 8;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] CMD_MASTER_RESET = 8'h01;
    localparam logic [7:0] CMD_PIN_REMAP = 8'h02;

    // synchroniser bit positions
    localparam int SYN_TCK = 0;
    localparam int SYN_TMS = 1;
    localparam int SYN_TDI = 2;
    localparam int SYN_WIDTH = 3;
    localparam logic [2:0] SYN_RESET = 3'h0;

    // tap controller states, gray steps in the order listed
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_SEL_DR = 4'h3,
        TAP_CAP_DR = 4'h2,
        TAP_SHIFT_DR = 4'h6,
        TAP_EXIT1_DR = 4'h7,
        TAP_PAUSE_DR = 4'h5,
        TAP_EXIT2_DR = 4'h4,
        TAP_UPD_DR = 4'hC,
        TAP_SEL_IR = 4'hD,
        TAP_CAP_IR = 4'hF,
        TAP_SHIFT_IR = 4'hE,
        TAP_EXIT1_IR = 4'hA,
        TAP_PAUSE_IR = 4'hB,
        TAP_EXIT2_IR = 4'h9,
        TAP_UPD_IR = 4'h8
    } jps_tap_type;

endpackage

// [src/jps_cmd_reg.sv]
/*
 * jps_cmd_reg: the 8-bit vendor command shift register with its
 * separate parallel latch. Assumes single-cycle capture, shift and
 * update strobes already qualified by the tap state and clock edges.
 */
`timescale 1ns/100ps

module jps_cmd_reg (
    // clock and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tap_reset,
    // strobes from the tap controller
    input wire logic capture_en,
    input wire logic shift_en,
    input wire logic update_en,
    // serial path
    input wire logic tdi,
    output logic serial_out,
    // latched command
    output logic [7:0] cmd_q
);

    logic [7:0] shift_q;

    // shift stages: capture reloads the live command for readback
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_q <= jps_pkg::CMD_RESET;
        end else if (capture_en) begin
            shift_q <= cmd_q;
        end else if (shift_en) begin
            shift_q <= {tdi, shift_q[7:1]}; // lsb first
        end
    end

    assign serial_out = shift_q[0];

    // separate latch, so partial patterns never act on logic
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_q <= jps_pkg::CMD_RESET;
        end else if (tap_reset) begin
            cmd_q <= jps_pkg::CMD_RESET;
        end else if (update_en) begin
            cmd_q <= shift_q;
        end
    end

    chk_latch_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!update_en && !tap_reset) |=> $stable(cmd_q))
        else $error("command latch moved outside update");

endmodule

// [src/jps_switch.sv]
/*
 * jps_switch: tap controller with instruction register, bypass and the
 * vendor command register; remaps the test pins onto the two-wire
 * programming engine. Assumes tck, tms and tdi are asynchronous pins
 * sampled by clk, which runs many times faster than tck.
 */
`timescale 1ns/100ps

module jps_switch (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo_q,
    output logic tdo_oe_q,
    // two-wire programming engine side
    input wire logic prog_data_out,
    input wire logic prog_data_out_en,
    output logic prog_clock_pin_q,
    output logic prog_data_pin_q,
    output logic pin_remap_to_serial_prog_q,
    output logic enhanced_prog_allow_q,
    // device reset request
    output logic port_master_reset_cmd_q
);

    logic [2:0] syn1_q, syn2_q, syn3_q, pin_q, pin_d;
    logic tck_rise, tck_fall, tms_s, tdi_s;
    jps_pkg::jps_tap_type state_q, state_d;
    logic [3:0] ir_shift_q, ir_q;
    logic bypass_q, cmd_sout, sel_cmd;
    logic [7:0] cmd_q;

    // next tap state from tms
    function automatic jps_pkg::jps_tap_type tap_next(
        input jps_pkg::jps_tap_type s, input logic m);
        unique case (s)
            jps_pkg::TAP_RESET: tap_next = m ? jps_pkg::TAP_RESET
                                            : jps_pkg::TAP_IDLE;
            jps_pkg::TAP_IDLE: tap_next = m ? jps_pkg::TAP_SEL_DR
                                           : jps_pkg::TAP_IDLE;
            jps_pkg::TAP_SEL_DR: tap_next = m ? jps_pkg::TAP_SEL_IR
                                             : jps_pkg::TAP_CAP_DR;
            jps_pkg::TAP_CAP_DR: tap_next = m ? jps_pkg::TAP_EXIT1_DR
                                             : jps_pkg::TAP_SHIFT_DR;
            jps_pkg::TAP_SHIFT_DR: tap_next = m ? jps_pkg::TAP_EXIT1_DR
                                               : jps_pkg::TAP_SHIFT_DR;
            jps_pkg::TAP_EXIT1_DR: tap_next = m ? jps_pkg::TAP_UPD_DR
                                               : jps_pkg::TAP_PAUSE_DR;
            jps_pkg::TAP_PAUSE_DR: tap_next = m ? jps_pkg::TAP_EXIT2_DR
                                               : jps_pkg::TAP_PAUSE_DR;
            jps_pkg::TAP_EXIT2_DR: tap_next = m ? jps_pkg::TAP_UPD_DR
                                               : jps_pkg::TAP_SHIFT_DR;
            jps_pkg::TAP_UPD_DR: tap_next = m ? jps_pkg::TAP_SEL_DR
                                             : jps_pkg::TAP_IDLE;
            jps_pkg::TAP_SEL_IR: tap_next = m ? jps_pkg::TAP_RESET
                                             : jps_pkg::TAP_CAP_IR;
            jps_pkg::TAP_CAP_IR: tap_next = m ? jps_pkg::TAP_EXIT1_IR
                                             : jps_pkg::TAP_SHIFT_IR;
            jps_pkg::TAP_SHIFT_IR: tap_next = m ? jps_pkg::TAP_EXIT1_IR
                                               : jps_pkg::TAP_SHIFT_IR;
            jps_pkg::TAP_EXIT1_IR: tap_next = m ? jps_pkg::TAP_UPD_IR
                                               : jps_pkg::TAP_PAUSE_IR;
            jps_pkg::TAP_PAUSE_IR: tap_next = m ? jps_pkg::TAP_EXIT2_IR
                                               : jps_pkg::TAP_PAUSE_IR;
            jps_pkg::TAP_EXIT2_IR: tap_next = m ? jps_pkg::TAP_UPD_IR
                                               : jps_pkg::TAP_SHIFT_IR;
            jps_pkg::TAP_UPD_IR: tap_next = m ? jps_pkg::TAP_SEL_DR
                                             : jps_pkg::TAP_IDLE;
        endcase
    endfunction

    // three-stage pin synchroniser; syn1 feeds only syn2
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            syn1_q <= jps_pkg::SYN_RESET;
            syn2_q <= jps_pkg::SYN_RESET;
            syn3_q <= jps_pkg::SYN_RESET;
        end else begin
            syn1_q <= {tdi, tms, tck};
            syn2_q <= syn1_q;
            syn3_q <= syn2_q;
        end
    end

    // a pin level counts only once stages two and three agree
    always_comb begin
        for (int i = 0; i < jps_pkg::SYN_WIDTH; i++) begin
            pin_d[i] = (syn2_q[i] == syn3_q[i]) ? syn3_q[i] : pin_q[i];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_q <= jps_pkg::SYN_RESET;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign tck_rise = pin_d[jps_pkg::SYN_TCK] & ~pin_q[jps_pkg::SYN_TCK];
    assign tck_fall = ~pin_d[jps_pkg::SYN_TCK] & pin_q[jps_pkg::SYN_TCK];
    assign tms_s = pin_q[jps_pkg::SYN_TMS];
    assign tdi_s = pin_q[jps_pkg::SYN_TDI];
    assign state_d = tap_next(state_q, tms_s);

    // tap controller steps on each rising test clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= jps_pkg::TAP_RESET;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

    // instruction shift and update; tap reset restores the default
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ir_shift_q <= jps_pkg::IR_RESET;
            ir_q <= jps_pkg::IR_RESET;
        end else if (state_q == jps_pkg::TAP_RESET) begin
            ir_q <= jps_pkg::IR_RESET;
        end else if (tck_rise && state_q == jps_pkg::TAP_CAP_IR) begin
            ir_shift_q <= jps_pkg::IR_CAPTURE;
        end else if (tck_rise && state_q == jps_pkg::TAP_SHIFT_IR) begin
            ir_shift_q <= {tdi_s, ir_shift_q[3:1]};
        end else if (tck_fall && state_q == jps_pkg::TAP_UPD_IR) begin
            ir_q <= ir_shift_q;
        end
    end

    // any other instruction sees the one-bit bypass stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bypass_q <= 1'b0;
        end else if (tck_rise && state_q == jps_pkg::TAP_CAP_DR) begin
            bypass_q <= 1'b0;
        end else if (tck_rise && state_q == jps_pkg::TAP_SHIFT_DR) begin
            bypass_q <= tdi_s;
        end
    end

    assign sel_cmd = (ir_q == jps_pkg::IR_VENDOR_CMD);

    jps_cmd_reg u_cmd (
        .clk(clk),
        .sys_rst(sys_rst),
        .tap_reset(state_q == jps_pkg::TAP_RESET),
        .capture_en(sel_cmd && tck_rise
                    && state_q == jps_pkg::TAP_CAP_DR),
        .shift_en(sel_cmd && tck_rise
                  && state_q == jps_pkg::TAP_SHIFT_DR),
        .update_en(sel_cmd && tck_fall
                   && state_q == jps_pkg::TAP_UPD_DR),
        .tdi(tdi_s),
        .serial_out(cmd_sout),
        .cmd_q(cmd_q)
    );

    // tdo: scan data on falling tck, engine data once remapped
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (pin_remap_to_serial_prog_q) begin
            tdo_q <= prog_data_out;
            tdo_oe_q <= prog_data_out_en;
        end else if (tck_fall) begin
            tdo_oe_q <= (state_q == jps_pkg::TAP_SHIFT_DR)
                     || (state_q == jps_pkg::TAP_SHIFT_IR);
            if (state_q == jps_pkg::TAP_SHIFT_IR) begin
                tdo_q <= ir_shift_q[0];
            end else begin
                tdo_q <= sel_cmd ? cmd_sout : bypass_q;
            end
        end
    end

    // remap and engine pins; the engine sees the filtered tck and tdi
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_remap_to_serial_prog_q <= 1'b0;
            enhanced_prog_allow_q <= 1'b1;
            prog_clock_pin_q <= 1'b0;
            prog_data_pin_q <= 1'b0;
        end else begin
            pin_remap_to_serial_prog_q <=
                (cmd_q == jps_pkg::CMD_PIN_REMAP);
            enhanced_prog_allow_q <=
                (cmd_q != jps_pkg::CMD_PIN_REMAP);
            prog_clock_pin_q <= (cmd_q == jps_pkg::CMD_PIN_REMAP)
                             && pin_q[jps_pkg::SYN_TCK];
            prog_data_pin_q <= (cmd_q == jps_pkg::CMD_PIN_REMAP) && tdi_s;
        end
    end

    // master reset is a separate output, so the tap keeps running
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_master_reset_cmd_q <= 1'b0;
        end else begin
            port_master_reset_cmd_q <=
                (cmd_q == jps_pkg::CMD_MASTER_RESET);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_cmd_scan;
        sel_cmd && !pin_remap_to_serial_prog_q && tck_fall
            && state_q == jps_pkg::TAP_SHIFT_DR;
    endsequence

    chk_cmd_scan_path: assert property (
        s_cmd_scan |=> tdo_q == $past(cmd_sout) && tdo_oe_q)
        else $error("command register not on scan path");

    chk_remap_follow: assert property (
        cmd_q == jps_pkg::CMD_PIN_REMAP |=> pin_remap_to_serial_prog_q)
        else $error("remap not raised after remap command");

    chk_remap_tdo: assert property (
        pin_remap_to_serial_prog_q |=> tdo_q == $past(prog_data_out)
            && tdo_oe_q == $past(prog_data_out_en))
        else $error("engine data not on tdo while remapped");

    chk_remap_clock: assert property (
        pin_remap_to_serial_prog_q ##1 pin_remap_to_serial_prog_q
            |-> prog_clock_pin_q == $past(pin_q[jps_pkg::SYN_TCK]))
        else $error("programming clock not following tck");

    chk_no_enhanced: assert property (
        pin_remap_to_serial_prog_q |-> !enhanced_prog_allow_q)
        else $error("enhanced method allowed while remapped");

    chk_master_reset: assert property (
        cmd_q == jps_pkg::CMD_MASTER_RESET |=> port_master_reset_cmd_q)
        else $error("master reset missing after reset command");

    // the reset request must leave the tap stepping normally
    chk_tap_unreset: assert property (
        port_master_reset_cmd_q && tck_rise |=> state_q == $past(state_d))
        else $error("tap disturbed by master reset");

    chk_tap_clear: assert property (
        state_q == jps_pkg::TAP_RESET |=> cmd_q == jps_pkg::CMD_RESET
            ##1 !port_master_reset_cmd_q && !pin_remap_to_serial_prog_q)
        else $error("tap reset did not clear the command");

endmodule

// [tb/jps_tool_model.sv]
/*
 * jps_tool_model: behavioural test-port tool that paces tck from clk.
 * Assumes clk at 4 ns, so one 16-clk tck period is 64 ns.
 * tck stands low outside scans, except while pins drives raw levels.
 */
`timescale 1ns/100ps

module jps_tool_model (
    // pacing clock
    input wire logic clk,
    // test port pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one 16-clk tck period; tdo read just before the rising edge
    // a released tdo reads as the inverse, so a missing enable shows
    task automatic tick(input logic m, input logic d, output logic q);
        @(posedge clk);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (8) @(posedge clk);
        q = tdo_oe ? tdo : ~tdo;
        tck <= 1'b1;
        repeat (7) @(posedge clk);
    endtask

    // park tck low; tdi flips so a stale level is never trusted
    task automatic park();
        @(posedge clk);
        tck <= 1'b0;
        tdi <= ~tdi;
        repeat (8) @(posedge clk);
    endtask

    // five tms-high periods reach test-logic-reset, then idle
    task automatic tap_reset();
        logic q;
        repeat (5) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        park();
    endtask

    // ir or dr scan from idle, lsb first, back to idle
    task automatic scan(input logic ir, input int n, input logic [7:0] v,
                        output logic [7:0] cap);
        logic q;
        cap = 8'h00;
        tick(1'b1, 1'b0, q);
        if (ir) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, v[i], q);
            cap[i] = q;
        end
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        park();
    endtask

    // raw pin levels while remapped; tms low keeps the tap in idle
    task automatic pins(input logic c, input logic d);
        @(posedge clk);
        tck <= c;
        tdi <= d;
        tms <= 1'b0;
    endtask
endmodule

// [tb/jps_switch_bench.sv]
/*
 * jps_switch_bench: self-checking bench for jps_switch with the tool
 * model on the test port. Assumes the switch alone, no engine model.
 */
`timescale 1ns/100ps
`define CHK(got, exp) chk(8'(got), 8'(exp))

module jps_switch_bench;
    logic clk, sys_rst, tck, tms, tdi, tdo, tdo_oe;
    logic pdo, pdo_en, pclk, pdat, remap_q, enh_q, mrst_q;
    logic [7:0] cap, exp_cap;
    int err_total = 0;
    int num_checks = 0;
    int remap_cnt = 0;
    int snap;
    typedef struct packed {
        logic [3:0] ir;
        logic [7:0] cmd;
        logic remap;
        logic mrst;
    } jps_row_type;
    jps_row_type rows [5] = '{
        '{4'h8, 8'h02, 1'b1, 1'b0}, '{4'h8, 8'h01, 1'b0, 1'b1},
        '{4'h8, 8'h55, 1'b0, 1'b0}, '{4'hF, 8'h02, 1'b0, 1'b0},
        '{4'h2, 8'h01, 1'b0, 1'b0}};

    jps_switch dut_u (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo_q(tdo), .tdo_oe_q(tdo_oe), .prog_data_out(pdo),
        .prog_data_out_en(pdo_en), .prog_clock_pin_q(pclk),
        .prog_data_pin_q(pdat), .pin_remap_to_serial_prog_q(remap_q),
        .enhanced_prog_allow_q(enh_q), .port_master_reset_cmd_q(mrst_q));
    jps_tool_model tool_u (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe));

    // 250 MHz clock
    initial clk = 1'b0;
    always #2 clk = ~clk;

    // counts remap cycles, to catch a glitch mid-shift
    always @(posedge clk) if (remap_q === 1'b1) remap_cnt++;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog: the run needs about 18 us
    initial begin
        #100000;
        err_total++;
        wrap_up();
    end

    initial begin
        sys_rst = 1'b1;
        pdo = 1'b0;
        pdo_en = 1'b0;
        repeat (5) @(posedge clk);
        `CHK({tdo_oe, pclk, pdat}, 3'b000);
        `CHK({remap_q, enh_q, mrst_q}, 3'b010);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        $display("test reset done");
        // table rows: instruction, command, expected levels
        foreach (rows[k]) begin
            tool_u.tap_reset();
            tool_u.scan(1'b1, 4, {4'h0, rows[k].ir}, cap);
            `CHK(cap, 8'h01);
            tool_u.scan(1'b0, 8, rows[k].cmd, cap);
            exp_cap = rows[k].ir == 4'h8 ? 8'h00 : {rows[k].cmd[6:0], 1'b0};
            `CHK(cap, exp_cap);
            repeat (4) @(posedge clk);
            `CHK(remap_q, rows[k].remap);
            `CHK(enh_q, !rows[k].remap);
            `CHK(mrst_q, rows[k].mrst);
            $display("test row %0d done", k);
        end
        // remap: pins follow tck, tdi and the engine's data
        tool_u.tap_reset();
        tool_u.scan(1'b1, 4, 8'h08, cap);
        tool_u.scan(1'b0, 8, 8'h02, cap);
        for (int j = 0; j < 4; j++) begin
            tool_u.pins(j[0], j[1]);
            pdo <= j[1];
            pdo_en <= j[0];
            repeat (8) @(posedge clk);
            `CHK({pclk, pdat, enh_q}, {j[0], j[1], 1'b0});
            `CHK({tdo, tdo_oe}, {j[1], j[0]});
        end
        // a new command replaces the remap without a tap reset
        tool_u.pins(1'b0, 1'b0);
        tool_u.scan(1'b0, 8, 8'h01, cap);
        repeat (4) @(posedge clk);
        `CHK({remap_q, enh_q, mrst_q}, 3'b011);
        tool_u.tap_reset();
        repeat (4) @(posedge clk);
        `CHK({remap_q, mrst_q}, 2'b00);
        $display("test remap done");
        // 0x01 passes 0x02 in the shift stages after seven bits
        tool_u.scan(1'b1, 4, 8'h08, cap);
        snap = remap_cnt;
        tool_u.scan(1'b0, 8, 8'h01, cap);
        repeat (4) @(posedge clk);
        `CHK(remap_cnt - snap, 0);
        `CHK(mrst_q, 1'b1);
        // tap still alive: readback of the latched command
        tool_u.scan(1'b0, 8, 8'h01, cap);
        `CHK(cap, 8'h01);
        tool_u.tap_reset();
        repeat (4) @(posedge clk);
        `CHK(mrst_q, 1'b0);
        $display("test master reset done");
        // mid-run system reset while remapped clears every output but enh_q, which returns to 1
        tool_u.scan(1'b1, 4, 8'h08, cap);
        tool_u.scan(1'b0, 8, 8'h02, cap);
        repeat (4) @(posedge clk);
        `CHK(remap_q, 1'b1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK({tdo_oe, pclk, pdat}, 3'b000);
        `CHK({remap_q, enh_q, mrst_q}, 3'b010);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK({remap_q, enh_q, mrst_q}, 3'b010);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule
